/* design/sadc_pkg.sv */
// Behaviour
// RULE_01: start edge begins conversion, powers core
// RULE_02: start requests ignored while converting
// RULE_03: busy high for whole conversion
// RULE_04: host keeps start quiet during conversion
// RULE_05: internal timer, conversion within 527ns
// RULE_06: host waits 460ns acquisition between conversions
// RULE_07: after conversion only core naps
// RULE_08: new start accepted before full readout
// RULE_09: host waits 100ms after power-on reset; the bench waits 4 clocks after srst falls
// RULE_10: two start pulses without clock request sleep
// RULE_11: sleep entered when busy falls
// RULE_12: serial clock rising edge wakes device
// RULE_13: host waits wake delay before converting
// RULE_14: serial port active only while enable low
// RULE_15: output changes, input sampled on rising clock
// RULE_16: top result bit valid before first edge
// RULE_17: result, then sequence flag, then config
// RULE_18: output low after 24 rising edges
// RULE_19: host clock rate sets throughput
// RULE_20: eight-bit control word in, MSB first
// RULE_21: sequence flag marks first sequencer slot
// RULE_22: reset leaves one all-zero sequencer word
// RULE_23: sequencer steps and wraps each conversion
// RULE_24: result loaded for readout when busy falls
package sadc_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_TIME_NS = 527;
   // longest time: round down
   localparam int CONV_CYCLES = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
      CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int RESULT_W = 16;
   localparam int CFG_W = 7;
   localparam int CTRL_W = 8;
   localparam int FRAME_BITS = 24;
   localparam int SEQ_DEPTH = 16;
   localparam int SEQ_PTR_W = 4;
   localparam int FIFO_DEPTH = 4;
   localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
   localparam int CFG_SEL_POS = 0;
   localparam int CFG_RANGE_LSB = 1;
   localparam int CFG_MUX_LSB = 3;
   localparam int CTRL_SEQ_BIT = 7;
   localparam logic [3:0] CONV_CNT_LAST = 4'(CONV_CYCLES - 1);
   localparam logic [4:0] FRAME_LAST = 5'(FRAME_BITS);
   localparam logic [3:0] CTRL_LAST = 4'(CTRL_W);
   typedef enum logic [1:0] {ST_NAP, ST_CONVERT, ST_SLEEP} sadc_state_t;
   typedef logic [RESULT_W+CFG_W:0] sadc_frame_t;
endpackage : sadc_pkg

/* design/sadc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   import sadc_pkg::*;
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } sadc_fifo_st_t;
   sadc_fifo_st_t s_r;
   sadc_fifo_st_t s_nxt;
   logic doPush;
   logic doPop;
   assign inReady = (s_r.count != (AW+1)'(DEPTH));
   assign outValid = (s_r.count != '0);
   assign outData = s_r.mem[s_r.rdPtr];
   assign doPush = inValid && inReady;
   assign doPop = outValid && outReady;
   always_comb begin
      s_nxt = s_r;
      if (doPush) begin
         s_nxt.mem[s_r.wrPtr] = inData;
         s_nxt.wrPtr = (s_r.wrPtr == AW'(DEPTH-1)) ? '0 : s_r.wrPtr + 1'b1;
      end
      if (doPop) begin
         s_nxt.rdPtr = (s_r.rdPtr == AW'(DEPTH-1)) ? '0 : s_r.rdPtr + 1'b1;
      end
      case ({doPush, doPop})
         2'b10: s_nxt.count = s_r.count + 1'b1;
         2'b01: s_nxt.count = s_r.count - 1'b1;
         default: s_nxt.count = s_r.count;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : sadc_fifo
`default_nettype wire

/* design/sadc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module sadc_core (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic convert_start,
   input wire logic serialClk,
   input wire logic serialDataIn,
   input wire logic serial_bus_enable_n,
   input wire logic [sadc_pkg::RESULT_W-1:0] convResult,
   output logic busy,
   output logic serialDataOut,
   output logic serialDataOutEn,
   output logic corePowered,
   output logic partAsleep,
   output logic [sadc_pkg::CFG_W-1:0] activeConfig,
   output logic [3:0] muxSelect,
   output logic [1:0] inputRange,
   output logic gainCompress
);
   import sadc_pkg::*;

   typedef struct packed {
      sadc_state_t st;
      logic [3:0] convCnt;
      logic busy;
      logic [1:0] startsNoClk;
      logic sleepReq;
      logic [SEQ_DEPTH-1:0][CFG_W-1:0] seqMem;
      logic [SEQ_PTR_W-1:0] seqPtr;
      logic [SEQ_PTR_W-1:0] seqLast;
      logic [CFG_W-1:0] cfgUsed;
      logic sosUsed;
      logic [FRAME_BITS-1:0] outShift;
      logic [4:0] outCnt;
      logic [CTRL_W-1:0] inShift;
      logic [3:0] inCnt;
      logic newCfgValid;
      logic [CFG_W-1:0] newCfg;
      logic sdo;
      logic sdoEn;
      logic pushValid;
      logic [FRAME_BITS-1:0] pushData;
      logic [1:0] cnvMeta;
      logic [1:0] cnvSync;
      logic cnvPrev;
      logic [1:0] sckMeta;
      logic [1:0] sckSync;
      logic sckPrev;
      logic sdiMeta;
      logic sdiSync;
      logic enMeta;
      logic enSync_n;
   } sadc_core_st_t;

   sadc_core_st_t s_r;
   sadc_core_st_t s_nxt;

   logic fifoOutValid;
   logic fifoOutReady;
   logic [FRAME_BITS-1:0] fifoOutData;
   logic cnvRise;
   logic sckRise;
   logic busActive;

   // wrap the sequencer pointer at the last programmed word
   function automatic logic [SEQ_PTR_W-1:0] seqNext(
      input logic [SEQ_PTR_W-1:0] ptr,
      input logic [SEQ_PTR_W-1:0] last
   );
      seqNext = (ptr == last) ? '0 : ptr + 1'b1;
   endfunction : seqNext

   function automatic logic [1:0] cfgRange(input logic [CFG_W-1:0] cfg);
      cfgRange = cfg[CFG_RANGE_LSB +: 2];
   endfunction : cfgRange

   assign cnvRise = s_r.cnvSync[0] && !s_r.cnvPrev;
   assign sckRise = s_r.sckSync[0] && !s_r.sckPrev;
   assign busActive = !s_r.enSync_n;

   // frames wait in the fifo while the bus is active and outCnt is not zero, so the
   // bits already shifted out are never torn by a late conversion
   assign fifoOutReady = !busActive || (s_r.outCnt == '0); // RULE_24

   sadc_fifo #(
      .WIDTH(FRAME_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .srst(srst),
      .inValid(s_r.pushValid),
      .inReady(),
      .inData(s_r.pushData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.pushValid = 1'b0;

      // two-flop synchronisers; only the second stage is looked at
      s_nxt.cnvMeta[0] = convert_start;
      s_nxt.cnvSync[0] = s_r.cnvMeta[0];
      s_nxt.cnvPrev = s_r.cnvSync[0];
      s_nxt.sckMeta[0] = serialClk;
      s_nxt.sckSync[0] = s_r.sckMeta[0];
      s_nxt.sckPrev = s_r.sckSync[0];
      s_nxt.sdiMeta = serialDataIn;
      s_nxt.sdiSync = s_r.sdiMeta;
      s_nxt.enMeta = serial_bus_enable_n;
      s_nxt.enSync_n = s_r.enMeta;
      s_nxt.cnvMeta[1] = 1'b0;
      s_nxt.cnvSync[1] = 1'b0;
      s_nxt.sckMeta[1] = 1'b0;
      s_nxt.sckSync[1] = 1'b0;

      // count start edges with no serial clock edge between them
      if (sckRise) begin
         s_nxt.startsNoClk = 2'h0;
      end else if (cnvRise && s_r.startsNoClk != 2'h2) begin
         s_nxt.startsNoClk = s_r.startsNoClk + 2'h1;
      end
      if (cnvRise && !sckRise && s_r.startsNoClk != 2'h0) begin
         s_nxt.sleepReq = 1'b1; // RULE_10
      end else if (sckRise && s_r.st != ST_CONVERT) begin
         s_nxt.sleepReq = 1'b0;
      end

      case (s_r.st)
         ST_NAP: begin
            // a start is never refused; with the fifo full the new frame is dropped
            if (cnvRise) begin // RULE_01 RULE_08
               s_nxt.st = ST_CONVERT;
               s_nxt.busy = 1'b1; // RULE_03
               s_nxt.convCnt = '0;
               if (s_r.newCfgValid) begin
                  s_nxt.seqMem[0] = s_r.newCfg;
                  s_nxt.seqLast = '0;
                  s_nxt.cfgUsed = s_r.newCfg;
                  s_nxt.sosUsed = 1'b1; // RULE_21
                  s_nxt.seqPtr = '0;
                  s_nxt.newCfgValid = 1'b0;
               end else begin
                  s_nxt.cfgUsed = s_r.seqMem[s_r.seqPtr];
                  s_nxt.sosUsed = (s_r.seqPtr == '0); // RULE_21
                  s_nxt.seqPtr = seqNext(s_r.seqPtr, s_r.seqLast); // RULE_23
               end
            end
         end
         ST_CONVERT: begin
            // further start edges are simply not looked at here
            if (s_r.convCnt == CONV_CNT_LAST) begin // RULE_02 RULE_05
               s_nxt.busy = 1'b0; // RULE_03
               s_nxt.pushValid = 1'b1; // RULE_24
               s_nxt.pushData = {convResult, s_r.sosUsed, s_r.cfgUsed}; // RULE_17
               if (s_r.sleepReq) begin
                  s_nxt.st = ST_SLEEP; // RULE_11
               end else begin
                  s_nxt.st = ST_NAP; // RULE_07
               end
            end else begin
               s_nxt.convCnt = s_r.convCnt + 4'h1;
            end
         end
         ST_SLEEP: begin
            if (sckRise) begin
               s_nxt.st = ST_NAP; // RULE_12
               s_nxt.sleepReq = 1'b0;
            end
         end
         default: begin
            s_nxt.st = ST_NAP;
            s_nxt.busy = 1'b0;
         end
      endcase

      // serial port: no shifting while asleep, the wake edge shifts nothing
      if (!busActive) begin
         s_nxt.outCnt = '0; // RULE_14
         s_nxt.inCnt = '0;
         s_nxt.sdoEn = 1'b0;
      end else begin
         s_nxt.sdoEn = 1'b1; // RULE_14
         if (sckRise && s_r.st != ST_SLEEP) begin // RULE_15
            if (s_r.outCnt != FRAME_LAST) begin
               s_nxt.outShift = {s_r.outShift[FRAME_BITS-2:0], 1'b0};
               s_nxt.outCnt = s_r.outCnt + 5'h1;
            end
            if (s_r.inCnt != CTRL_LAST) begin
               s_nxt.inShift = {s_r.inShift[CTRL_W-2:0], s_r.sdiSync}; // RULE_20
               s_nxt.inCnt = s_r.inCnt + 4'h1;
               // programming words (top bit set) are not handled here
               if (s_r.inCnt == CTRL_LAST - 4'h1 && !s_r.inShift[CTRL_SEQ_BIT-1]) begin
                  s_nxt.newCfg = {s_r.inShift[CFG_W-2:0], s_r.sdiSync}; // RULE_20
                  s_nxt.newCfgValid = 1'b1;
               end
            end
         end
      end

      if (fifoOutValid && fifoOutReady) begin
         s_nxt.outShift = fifoOutData; // RULE_16 RULE_24
         s_nxt.outCnt = '0;
      end

      // output is low once the whole frame has gone
      if (s_nxt.outCnt == FRAME_LAST) begin
         s_nxt.sdo = 1'b0; // RULE_18
      end else begin
         s_nxt.sdo = s_nxt.outShift[FRAME_BITS-1]; // RULE_16 RULE_17
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_r <= '0;
         s_r.st <= ST_NAP;
         s_r.enSync_n <= 1'b1;
         s_r.enMeta <= 1'b1;
         s_r.outCnt <= FRAME_LAST;
         s_r.seqMem <= '0; // RULE_22
         s_r.seqLast <= '0; // RULE_22
         s_r.seqPtr <= '0;
         s_r.cfgUsed <= CFG_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = s_r.busy;
   assign serialDataOut = s_r.sdo;
   assign serialDataOutEn = s_r.sdoEn;
   assign corePowered = (s_r.st == ST_CONVERT); // RULE_07
   assign partAsleep = (s_r.st == ST_SLEEP); // RULE_11
   assign activeConfig = s_r.cfgUsed;
   assign muxSelect = s_r.cfgUsed[CFG_MUX_LSB +: 4];
   assign inputRange = cfgRange(s_r.cfgUsed);
   // gain compression has no meaning in the unipolar range
   assign gainCompress = s_r.cfgUsed[CFG_SEL_POS] && (cfgRange(s_r.cfgUsed) != 2'h0);
endmodule : sadc_core
`default_nettype wire

/* bench/sadc_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sadc_core_checker (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic serialClk,
   input wire logic serial_bus_enable_n,
   input wire logic busy,
   input wire logic serialDataOut,
   input wire logic serialDataOutEn,
   input wire logic corePowered,
   input wire logic partAsleep,
   input wire logic [sadc_pkg::CFG_W-1:0] activeConfig,
   input wire logic [3:0] muxSelect,
   input wire logic [1:0] inputRange,
   input wire logic gainCompress
);
   import sadc_pkg::*;
   logic [2:0] sckSync_r;
   logic [4:0] rises_r;
   // own edge count; slack below covers sync latency
   always_ff @(posedge clk_sys) begin
      sckSync_r <= {sckSync_r[1:0], serialClk};
      if (srst || serial_bus_enable_n)
         rises_r <= 5'h00;
      else if (sckSync_r[1] && !sckSync_r[2] && rises_r < 5'h18)
         rises_r <= rises_r + 5'h01;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   busy_length_a: assert property (
      $rose(busy) |-> busy[*8] ##1 busy[*5] ##1 !busy) else $error("busy length wrong");
   no_restart_a: assert property (
      $fell(busy) |=> !busy) else $error("conversion restarted at once");
   core_power_a: assert property (
      busy |-> corePowered) else $error("core off while converting");
   nap_core_a: assert property (
      $fell(busy) |-> !corePowered) else $error("core left powered");
   port_enable_a: assert property (
      (!serial_bus_enable_n && !partAsleep)[*5] |-> serialDataOutEn)
      else $error("serial out not driven");
   port_quiet_a: assert property (
      serial_bus_enable_n[*5] |-> !serialDataOutEn) else $error("serial out driven");
   sleep_power_a: assert property (
      partAsleep |-> !busy && !corePowered) else $error("active while asleep");
   sleep_entry_a: assert property (
      $rose(partAsleep) |-> $past(busy) || $past(busy, 2)) else $error("sleep not at busy end");
   sleep_wake_a: assert property (
      partAsleep && $rose(serialClk) |-> ##[1:8] !partAsleep) else $error("no wake");
   tail_low_a: assert property (
      (rises_r == 5'h18)[*4] |-> !serialDataOut) else $error("output not low after frame");
   cfg_decode_a: assert property (
      muxSelect == activeConfig[6:3] && inputRange == activeConfig[2:1] &&
      gainCompress == (activeConfig[0] && activeConfig[2:1] != 2'h0))
      else $error("config decode wrong");
   reset_cfg_a: assert property (
      $fell(srst) |-> activeConfig == 7'h00) else $error("config not cleared");
endmodule : sadc_core_checker
bind sadc_core sadc_core_checker chk_i (.clk_sys, .srst, .serialClk, .serial_bus_enable_n,
   .busy, .serialDataOut, .serialDataOutEn, .corePowered, .partAsleep, .activeConfig,
   .muxSelect, .inputRange, .gainCompress);
`default_nettype wire

/* bench/sadc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model (
   input wire logic clk_sys,
   input wire logic busy,
   input wire logic serialDataOut,
   output logic convert_start,
   output logic serialClk,
   output logic serialDataIn,
   output logic serial_bus_enable_n
);
   parameter int WAKE_CYC = 20; // shortened wake delay
   initial begin
      convert_start = 1'h0;
      serialClk = 1'h0;
      serialDataIn = 1'h0;
      serial_bus_enable_n = 1'h1;
   end
   // start held through busy: no edge inside the conversion
   task automatic conv();
      int n;
      @(posedge clk_sys) convert_start <= 1'h1;
      for (n = 0; n < 10 && !busy; n++) @(posedge clk_sys);
      for (n = 0; n < 30 && busy; n++) @(posedge clk_sys);
      convert_start <= 1'h0;
      repeat (12) @(posedge clk_sys);
   endtask : conv
   // clock runs only inside the frame, 320 ns period
   task automatic rd(input int nb, input logic [7:0] ctl, output logic [24:0] got);
      int k;
      @(posedge clk_sys) serial_bus_enable_n <= 1'h0;
      serialDataIn <= ctl[7];
      repeat (8) @(posedge clk_sys);
      for (k = 0; k < nb; k++) begin
         got[24-k] = serialDataOut;
         serialClk <= 1'h1;
         repeat (4) @(posedge clk_sys);
         serialClk <= 1'h0;
         serialDataIn <= (k < 7) ? ctl[6-k] : ~serialDataIn;
         repeat (4) @(posedge clk_sys);
      end
      got[24-nb] = serialDataOut;
      serial_bus_enable_n <= 1'h1;
   endtask : rd
   // idleBus high gives a clock pulse that the disabled port must ignore
   task automatic wake(input logic idleBus);
      @(posedge clk_sys) serial_bus_enable_n <= idleBus;
      serialClk <= 1'h1;
      repeat (4) @(posedge clk_sys);
      serialClk <= 1'h0;
      serial_bus_enable_n <= 1'h1;
      repeat (WAKE_CYC) @(posedge clk_sys);
   endtask : wake
endmodule : sadc_host_model
`default_nettype wire

/* bench/sar_adc_conversion_and_serial_readout_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_and_serial_readout_tb_top;
   import sadc_pkg::*;
   logic clk_sys = 1'h0;
   logic srst = 1'h1;
   logic [RESULT_W-1:0] convResult = 16'h0000;
   logic convert_start, serialClk, serialDataIn, serial_bus_enable_n;
   logic busy, serialDataOut, serialDataOutEn, corePowered, partAsleep, gainCompress;
   logic [CFG_W-1:0] activeConfig;
   logic [3:0] muxSelect;
   logic [1:0] inputRange;
   logic [24:0] got;
   logic [6:0] cfgExp = 7'h00;
   int fail_count = 0;
   int n_compared = 0;
   always #20 clk_sys = ~clk_sys;
   sadc_core DUT (.clk_sys, .srst, .convert_start, .serialClk, .serialDataIn,
      .serial_bus_enable_n, .convResult, .busy, .serialDataOut, .serialDataOutEn,
      .corePowered, .partAsleep, .activeConfig, .muxSelect, .inputRange, .gainCompress);
   sadc_host_model host (.clk_sys, .busy, .serialDataOut, .convert_start, .serialClk,
      .serialDataIn, .serial_bus_enable_n);
   task automatic chk(input string nm, input logic [24:0] e, input logic [24:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // single slot sequencer: flag always set, tail low
   function automatic logic [24:0] frm(input logic [15:0] r, input logic [6:0] c);
      return {r, 1'h1, c, 1'h0};
   endfunction : frm
   task automatic step(input logic [7:0] c);
      convResult <= 16'($urandom);
      host.conv();
      chk("config", {18'h0, cfgExp}, {18'h0, activeConfig});
      host.rd(24, c, got);
      chk("frame", frm(convResult, cfgExp), got);
      if (!c[7])
         cfgExp = c[6:0];
   endtask : step
   initial begin
      void'($urandom(32'h4123));
      repeat (10) @(posedge clk_sys);
      srst <= 1'h0;
      repeat (4) @(posedge clk_sys);
      step(8'h80);
      step(8'h01);
      repeat (6) step(8'($urandom));
      step(8'h7F);
      convResult <= 16'hA5C3;
      host.conv();
      host.rd(16, 8'h80, got);
      chk("partial", {16'hA5C3, 9'h000}, {got[24:9], 9'h000});
      step(8'h80);
      host.conv();
      host.conv();
      chk("asleep", 25'h1, {24'h0, partAsleep});
      host.wake(1'h0);
      chk("awake", 25'h0, {24'h0, partAsleep});
      step(8'h80);
      convResult <= 16'h5AC3;
      host.conv();
      host.wake(1'h1);
      host.rd(24, 8'h80, got);
      chk("disabled clock", frm(16'h5AC3, cfgExp), got);
      wrap_up();
   end
   initial begin
      #1000000;
      fail_count++;
      wrap_up();
   end
endmodule : sar_adc_conversion_and_serial_readout_tb_top
`default_nettype wire
